// ===== verilog/sbl_ctrl.sv
// Host-side controller for an asynchronous 16-bit byte-lane static memory.
// Assumes a single 125 MHz clock; memory data pins resolved by the bench from enables.
`timescale 1ns/1ps
module sbl_ctrl
  import sbl_pkg::*;
(
  input wire logic CLK, // System clock
  input wire logic NRST, // Async reset, active low
  input wire logic REQ_VALID, // Request offered
  input wire sbl_req_s REQ, // Request contents
  output logic REQ_READY, // Request taken when high with valid, at least one lane enabled and no retention request
  output logic RSP_VALID, // Read data valid, one cycle
  output logic [SBL_DW-1:0] RSP_DATA, // Read data
  input wire logic RET_REQ, // Ask for retention entry
  output logic RET_OK, // Chip deselected, retention may start
  output logic [SBL_AW-1:0] MEM_ADDR, // Word address
  output logic MEM_SEL_LOW_ACTIVE_N, // Select, active low
  output logic MEM_SEL_HIGH_ACTIVE, // Select, active high
  output logic MEM_WRITE_N, // Write strobe, active low
  output logic MEM_GATE_N, // Output gate, active low
  output logic MEM_UPPER_LANE_ENABLE_N, // Upper lane enable
  output logic MEM_LOWER_LANE_ENABLE_N, // Lower lane enable
  input wire logic [SBL_DW-1:0] MEM_DQ_I, // Data from pins
  output logic [SBL_DW-1:0] MEM_DQ_O, // Data to pins
  output logic MEM_DQ_OE_N // Data drive enable, low drives
);
  // ==========================================================================
  // State
  sbl_state_e state;
  sbl_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic was_read;
  logic cnt_done;
  logic take;
  logic any_lane;
  // Request decode
  assign any_lane = ~(REQ.lane_n[0] & REQ.lane_n[1]);
  // Retention has priority, so a request is never taken while it is asked for
  assign take = REQ_READY & REQ_VALID & any_lane & ~RET_REQ;
  assign cnt_done = (cnt == CNT_ONE);
  // Next-state selection
  always_comb begin
    next_state = state;
    next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
    unique case (state)
      ST_IDLE: begin
        if (RET_REQ) begin
          next_state = ST_RET;
          next_cnt = CNT_W'(RET_CYC);
        end else if (take && !REQ.write) begin
          next_state = ST_READ;
          next_cnt = CNT_W'(RD_CYC);
        end else if (take && was_read) begin
          next_state = ST_TURN;
          next_cnt = CNT_W'(TURN_CYC);
        end else if (take) begin
          next_state = ST_WSET;
        end
      end
      ST_TURN: begin
        if (cnt_done) begin
          next_state = ST_WSET;
        end
      end
      ST_WSET: begin
        next_state = ST_WLOW;
        next_cnt = CNT_W'(WR_LOW_CYC);
      end
      ST_WLOW: begin
        if (cnt_done) begin
          next_state = ST_WEND;
          next_cnt = CNT_W'(WR_HOLD_CYC);
        end
      end
      ST_WEND: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_RET: begin
        if (!RET_REQ) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end
  // Held request, captured when taken
  sbl_req_s hold;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold <= '0;
    end else if (take) begin
      hold <= REQ;
    end
  end
  // Sequencer state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      was_read <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (take) begin
        was_read <= ~REQ.write;
      end else if (state == ST_TURN) begin
        was_read <= 1'b0;
      end
    end
  end
  // Pin controls decoded from the next state; address, data and lanes from the taken or held request
  logic n_sel;
  logic n_wr_n;
  logic n_gate_n;
  logic n_drive;
  logic [1:0] n_lane_n;
  logic [SBL_AW-1:0] n_addr;
  logic [SBL_DW-1:0] n_dq;
  logic n_busy;
  assign n_busy = (next_state != ST_IDLE) && (next_state != ST_RET) && (next_state != ST_TURN);
  assign n_sel = n_busy;
  assign n_wr_n = ~(next_state == ST_WLOW);
  assign n_gate_n = ~(next_state == ST_READ);
  assign n_drive = (next_state == ST_WSET) || (next_state == ST_WLOW) || (next_state == ST_WEND);
  assign n_addr = take ? REQ.addr : hold.addr;
  assign n_dq = (take ? REQ.wdata : hold.wdata);
  assign n_lane_n = n_busy ? (take ? REQ.lane_n : hold.lane_n) : 2'b11;
  // Registered pin drivers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MEM_ADDR <= '0;
      MEM_SEL_LOW_ACTIVE_N <= 1'b1;
      MEM_SEL_HIGH_ACTIVE <= 1'b0;
      MEM_WRITE_N <= 1'b1;
      MEM_GATE_N <= 1'b1;
      MEM_UPPER_LANE_ENABLE_N <= 1'b1;
      MEM_LOWER_LANE_ENABLE_N <= 1'b1;
      MEM_DQ_O <= '0;
      MEM_DQ_OE_N <= 1'b1;
    end else begin
      MEM_ADDR <= n_addr;
      MEM_SEL_LOW_ACTIVE_N <= ~n_sel;
      MEM_SEL_HIGH_ACTIVE <= n_sel;
      MEM_WRITE_N <= n_wr_n;
      MEM_GATE_N <= n_gate_n;
      MEM_UPPER_LANE_ENABLE_N <= n_lane_n[1];
      MEM_LOWER_LANE_ENABLE_N <= n_lane_n[0];
      MEM_DQ_O <= n_dq;
      MEM_DQ_OE_N <= ~n_drive;
    end
  end
  // User-side handshake and read return
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= '0;
      RET_OK <= 1'b0;
    end else begin
      REQ_READY <= (next_state == ST_IDLE) && !take;
      RSP_VALID <= (state == ST_READ) && cnt_done;
      if ((state == ST_READ) && cnt_done) begin
        // Disabled lanes return zero
        RSP_DATA <= MEM_DQ_I & {{SBL_LANE_W{~hold.lane_n[1]}}, {SBL_LANE_W{~hold.lane_n[0]}}};
      end
      RET_OK <= (next_state == ST_RET) && (state == ST_RET) && (cnt <= CNT_ONE);
    end
  end
  // ==========================================================================
  // Assertions
  sequence s_wr_low;
    !MEM_WRITE_N [*6];
  endsequence
  property p_wr_width;
    @(posedge CLK) disable iff (!NRST) $fell(MEM_WRITE_N) |-> s_wr_low ##1 MEM_WRITE_N;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("Write strobe width wrong");
  property p_read_strobe;
    @(posedge CLK) disable iff (!NRST) !MEM_GATE_N |-> MEM_WRITE_N && MEM_DQ_OE_N;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("Strobe low in read");
  property p_gate_write;
    @(posedge CLK) disable iff (!NRST) !MEM_WRITE_N |-> MEM_GATE_N;
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("Gate low in write");
  property p_write_qual;
    @(posedge CLK) disable iff (!NRST) !MEM_WRITE_N |-> !MEM_SEL_LOW_ACTIVE_N && MEM_SEL_HIGH_ACTIVE
      && !(MEM_UPPER_LANE_ENABLE_N && MEM_LOWER_LANE_ENABLE_N);
  endproperty
  a_write_qual: assert property (p_write_qual) else $error("Write not qualified");
  property p_data_hold;
    @(posedge CLK) disable iff (!NRST) $rose(MEM_WRITE_N) |-> $stable(MEM_DQ_O) && !MEM_DQ_OE_N;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("Data not held at write end");
  property p_desel_strobe;
    @(posedge CLK) disable iff (!NRST) $rose(MEM_SEL_LOW_ACTIVE_N) |-> $past(MEM_WRITE_N) && MEM_WRITE_N;
  endproperty
  a_desel_strobe: assert property (p_desel_strobe) else $error("Deselect with strobe low");
  property p_lane_early;
    @(posedge CLK) disable iff (!NRST) $fell(MEM_WRITE_N) |-> $past(!MEM_LOWER_LANE_ENABLE_N
      || !MEM_UPPER_LANE_ENABLE_N);
  endproperty
  a_lane_early: assert property (p_lane_early) else $error("Lanes late for write");
  property p_ret_desel;
    @(posedge CLK) disable iff (!NRST) RET_OK |-> MEM_SEL_LOW_ACTIVE_N && !MEM_SEL_HIGH_ACTIVE;
  endproperty
  a_ret_desel: assert property (p_ret_desel) else $error("Retention while selected");
  property p_no_clash;
    @(posedge CLK) disable iff (!NRST) $fell(MEM_GATE_N) |-> MEM_DQ_OE_N [*6];
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("Bus drive during read");
endmodule : sbl_ctrl

// ===== verilog/sbl_pkg.sv
// Package for the byte-lane static memory controller.
// Assumes a 125 MHz system clock and an asynchronous 16-bit memory outside.
package sbl_pkg;
  // ==========================================================================
  // Geometry
  localparam int SBL_AW = 20;
  localparam int SBL_DW = 16;
  localparam int SBL_LANE_W = 8;
  // ==========================================================================
  // Timing, in ns, and derived cycle counts at the system clock rate
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_READ_CYCLE_NS = 45;
  localparam int T_LANE_TO_WRITE_END_NS = 35;
  localparam int T_WRITE_DATA_SETUP_MIN_NS = 25;
  localparam int T_STROBE_TO_FLOAT_MAX_NS = 18;
  localparam int T_WRITE_CYCLE_NS = 45;
  localparam int T_DESELECT_TO_RETENTION_NS = 0;
  localparam int T_TURNAROUND_NS = 18;
  // Least times round up; none below one cycle
  function automatic int sbl_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : sbl_cyc_up
  localparam int RD_CYC = sbl_cyc_up(T_READ_CYCLE_NS);
  localparam int WR_LOW_CYC_A = sbl_cyc_up(T_WRITE_DATA_SETUP_MIN_NS + T_STROBE_TO_FLOAT_MAX_NS);
  localparam int WR_LOW_CYC_B = sbl_cyc_up(T_LANE_TO_WRITE_END_NS);
  localparam int WR_LOW_CYC = (WR_LOW_CYC_A > WR_LOW_CYC_B) ? WR_LOW_CYC_A : WR_LOW_CYC_B;
  localparam int WR_HOLD_CYC = 1;
  localparam int TURN_CYC = sbl_cyc_up(T_TURNAROUND_NS);
  localparam int RET_CYC = sbl_cyc_up(T_DESELECT_TO_RETENTION_NS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic write;
    logic [1:0] lane_n;
    logic [SBL_AW-1:0] addr;
    logic [SBL_DW-1:0] wdata;
  } sbl_req_s;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_READ = 7'h02,
    ST_WSET = 7'h04,
    ST_WLOW = 7'h08,
    ST_WEND = 7'h10,
    ST_TURN = 7'h20,
    ST_RET = 7'h40
  } sbl_state_e;
endpackage : sbl_pkg

// ===== testbench/sbl_mem_model.sv
// ==========================================================================
// Behavioural byte-lane static memory on the far side of the controller.
// Assumes the bench resolves the data wire from the controller drive enable alone.
`timescale 1ns/1ps
module sbl_mem_model
  import sbl_pkg::*;
(
  input wire logic clk, // Bench clock, only paces the floating pattern
  input wire logic [SBL_AW-1:0] addr, // Word address
  input wire logic sel_n, // Select, active low
  input wire logic sel_h, // Select, active high
  input wire logic we_n, // Write strobe
  input wire logic oe_n, // Output gate
  input wire logic [1:0] lane_n, // Lane enables, bit 1 upper
  input wire logic [SBL_DW-1:0] dq_in, // Resolved bus
  output logic [SBL_DW-1:0] dq_out, // Value the memory puts out
  output logic [1:0] drv // Lanes driven by the memory
);
  logic [SBL_DW-1:0] mem [bit [SBL_AW-1:0]];
  logic [SBL_DW-1:0] word = 16'h0000;
  logic [SBL_DW-1:0] junk = 16'h3c96;
  wire on = !sel_n && sel_h && (lane_n != 2'b11);
  wire wr = on && !we_n;
  wire rd = on && we_n && !oe_n;
  // Store enabled lanes for as long as the write overlap lasts
  always @(addr or on or wr or lane_n or dq_in) begin
    if (on) begin
      if (!mem.exists(addr)) mem[addr] = 16'h0000;
      if (wr && !lane_n[0]) mem[addr][7:0] = dq_in[7:0];
      if (wr && !lane_n[1]) mem[addr][15:8] = dq_in[15:8];
      word = mem[addr];
    end
  end
  // A released lane shows a pattern that moves every cycle
  always @(posedge clk) junk <= junk + 16'h3b1d;
  assign drv = rd ? ~lane_n : 2'b00;
  assign dq_out = {drv[1] ? word[15:8] : junk[15:8], drv[0] ? word[7:0] : junk[7:0]};
endmodule : sbl_mem_model

// ===== testbench/async_sram_byte_lane_access_tb.sv
// ==========================================================================
// Self-checking bench for the byte-lane static memory controller.
// Assumes the package, the controller and the memory model are compiled first.
`timescale 1ns/1ps
module async_sram_byte_lane_access_tb;
  import sbl_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic REQ_VALID = 1'b0;
  sbl_req_s REQ = '0;
  logic RET_REQ = 1'b0;
  logic REQ_READY, RSP_VALID, RET_OK, sel_n, sel_h, we_n, oe_n, up_n, lo_n, dq_oe_n;
  logic [SBL_DW-1:0] RSP_DATA, dq_o, dq_m, dq_bus;
  logic [SBL_AW-1:0] addr;
  logic [1:0] m_drv;
  int error_cnt = 0;
  int samples_checked = 0;
  int wlow = 0;
  int llow = 0;
  logic [31:0] seed = 32'h0000_3870;
  logic [SBL_DW-1:0] ref_mem [int];
  assign dq_bus = !dq_oe_n ? dq_o : dq_m;
  initial forever #4 CLK = ~CLK;
  sbl_ctrl DUT (.CLK(CLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RET_REQ(RET_REQ), .RET_OK(RET_OK), .MEM_ADDR(addr),
    .MEM_SEL_LOW_ACTIVE_N(sel_n), .MEM_SEL_HIGH_ACTIVE(sel_h), .MEM_WRITE_N(we_n), .MEM_GATE_N(oe_n),
    .MEM_UPPER_LANE_ENABLE_N(up_n), .MEM_LOWER_LANE_ENABLE_N(lo_n), .MEM_DQ_I(dq_bus), .MEM_DQ_O(dq_o),
    .MEM_DQ_OE_N(dq_oe_n));
  sbl_mem_model u_mem (.clk(CLK), .addr(addr), .sel_n(sel_n), .sel_h(sel_h), .we_n(we_n), .oe_n(oe_n),
    .lane_n({up_n, lo_n}), .dq_in(dq_bus), .dq_out(dq_m), .drv(m_drv));
  // Pseudo-random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // One access: offer, wait for the take edge, then follow the read answer
  task automatic access(input logic wr, input logic [1:0] ln, input logic [SBL_AW-1:0] a,
    input logic [SBL_DW-1:0] d);
    int n;
    logic rdy;
    logic [SBL_DW-1:0] e;
    @(posedge CLK);
    REQ <= '{write: wr, lane_n: ln, addr: a, wdata: d};
    REQ_VALID <= 1'b1;
    n = 0;
    rdy = 1'b0;
    while (!rdy && n < 50) begin
      #1 rdy = REQ_READY;
      @(posedge CLK);
      n++;
    end
    REQ_VALID <= 1'b0;
    if (!rdy) begin
      check(0, 1, "request not taken");
      give_verdict();
    end
    e = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
    if (wr) begin
      if (!ln[0]) e[7:0] = d[7:0];
      if (!ln[1]) e[15:8] = d[15:8];
      ref_mem[a] = e;
    end else begin
      n = 0;
      do begin @(posedge CLK); #1 n++; end while (RSP_VALID !== 1'b1 && n < 20);
      check(n, RD_CYC, "read latency");
      if (n >= 20) give_verdict();
      check(RSP_DATA, e & {{8{!ln[1]}}, {8{!ln[0]}}}, "read word");
    end
  endtask : access
  // Pin watch on the falling edge, where the controller outputs have settled
  always @(negedge CLK) begin
    if (NRST) begin
      check($isunknown({sel_n, sel_h, we_n, oe_n, up_n, lo_n}), 0, "control level");
      if (!oe_n) check(we_n, 1, "strobe in read");
      if (!we_n) check(oe_n, 1, "gate in write");
      if (!dq_oe_n) check(m_drv, 0, "bus contention");
      if (we_n && wlow > 0) begin
        check(wlow >= 6, 1, "strobe width");
        check(llow >= 5, 1, "lane lead");
        check(dq_oe_n, 0, "data at write end");
      end
      wlow = we_n ? 0 : wlow + 1;
      llow = (up_n && lo_n) ? 0 : llow + 1;
    end
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    int n;
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
    for (int k = 0; k < 3; k++) begin
      r = xs();
      access(1'b1, 2'(k), {4'h9, r[31:16]}, r[15:0]);
      access(1'b0, 2'(k), {4'h9, r[31:16]}, 16'h0000);
    end
    $display("test lane codes done");
    @(posedge CLK);
    REQ <= '{write: 1'b1, lane_n: 2'b11, addr: 20'h0_0001, wdata: 16'hffff};
    REQ_VALID <= 1'b1;
    repeat (10) @(posedge CLK);
    #1 check({REQ_READY, sel_n, we_n}, 3'b111, "no-lane request");
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    RET_REQ <= 1'b1;
    n = 0;
    do begin @(posedge CLK); #1 n++; end while (RET_OK !== 1'b1 && n < 20);
    // One edge to enter retention, then the deselect interval
    check(n, RET_CYC + 1, "retention grant");
    if (n >= 20) give_verdict();
    check({sel_n, sel_h, up_n, lo_n}, 4'hb, "deselected in retention");
    @(posedge CLK);
    RET_REQ <= 1'b0;
    $display("test deselect done");
    for (int k = 0; k < 40; k++) begin
      r = xs();
      access(r[2], (r[1:0] == 2'b11) ? 2'b00 : r[1:0], {17'h1_a5a5, r[5:3]}, r[31:16]);
    end
    $display("test random traffic done");
    give_verdict();
  end
endmodule : async_sram_byte_lane_access_tb
